// >>> dcfd_classify.v
// opcode classifier: category, sub-format and two-word detection
`include "dcfd_defs.vh"
module dcfd_classify (
  // opcode in
  input  wire [7:0] opcode,
  // classification out
  output reg  [2:0] category,
  output reg  [2:0] sub_format,
  output reg        two_word
);
  always @* begin
    category   = `DCFD_CAT_CONTROL;
    sub_format = `DCFD_SUB_NONE;
    two_word   = (opcode == `DCFD_OPC_TWOWORD_A) || (opcode == `DCFD_OPC_TWOWORD_B) ||
                 (opcode == `DCFD_OPC_TWOWORD_C);
    if (opcode == `DCFD_OPC_NOP) begin
      category = `DCFD_CAT_NOP;
    end else if (opcode[7:6] == 2'b01) begin
      category   = `DCFD_CAT_WORDBYTE;
      sub_format = opcode[5] ? `DCFD_SUB_FILE : `DCFD_SUB_DEFAULT_DEST_REGISTER;
    end else if (opcode[7:4] == 4'ha) begin
      category = `DCFD_CAT_BIT;
    end else if (opcode[7:4] == 4'h2 || opcode[7:4] == 4'hb) begin
      category   = `DCFD_CAT_LITERAL;
      sub_format = (opcode[7:4] == 4'h2) ? `DCFD_SUB_LITMOVE : `DCFD_SUB_LITALU;
    end else if (opcode[7:4] == 4'hc) begin
      category   = `DCFD_CAT_DSP;
      sub_format = opcode[3] ? `DCFD_SUB_DSPOTHER : `DCFD_SUB_MAC;
    end
  end
endmodule // dcfd_classify

// >>> dcfd_decoder.v
// instruction format decoder top: word gathering and operand extraction
`include "dcfd_defs.vh"
module dcfd_decoder #(
  parameter WORD_W = `DCFD_WORD_W
) (
  // clock and reset
  input  wire              clk,
  input  wire              reset_n,
  // fetch side
  input  wire [WORD_W-1:0] fetch_word,
  input  wire              fetch_valid,
  input  wire              flow_change,
  // issue side
  output reg               issue_valid_q,
  output reg  [2:0]        category_q,
  output reg  [2:0]        sub_format_q,
  output reg  [7:0]        opcode_q,
  output reg               two_word_q,
  output reg  [WORD_W-1:0] ext_word_q,
  output reg  [3:0]        base_reg_operand_q,
  output reg  [6:0]        source_reg_operand_q,
  output reg  [6:0]        dest_reg_operand_q,
  output reg  [12:0]       file_addr_q,
  output reg               default_dest_register_q,
  output reg  [3:0]        bit_select_q,
  output reg               bit_sel_by_reg_q,
  output reg  [15:0]       literal_q,
  output reg               acc_sel_q,
  output reg  [2:0]        mul_pair_q,
  output reg  [3:0]        x_prefetch_q,
  output reg  [3:0]        y_prefetch_q,
  output reg  [1:0]        awb_q,
  output reg  [3:0]        shift_amount_reg_q,
  output reg               shift_by_reg_q
);
  localparam ST_IDLE = 3'b001;
  localparam ST_EXT  = 3'b010;
  localparam ST_BUB  = 3'b100;

  // opcode sits in the top byte of a first word
  function [7:0] opc_of;
    input [WORD_W-1:0] word;
    begin
      opc_of = word[`DCFD_OPC_MSB:`DCFD_OPC_LSB];
    end
  endfunction

  // sequencing state
  reg  [2:0]        state_q;
  reg  [2:0]        state_d;
  reg  [WORD_W-1:0] first_q;
  reg  [WORD_W-1:0] first_d;
  wire [7:0]        opc      = opc_of(fetch_word);
  wire [7:0]        held_opc = opc_of(first_q);
  wire [7:0]        cls_opc  = (state_q == ST_EXT) ? held_opc : opc;

  // next values of the issue registers
  reg               issue_valid_d;
  reg  [2:0]        category_d;
  reg  [2:0]        sub_format_d;
  reg  [7:0]        opcode_d;
  reg               two_word_d;
  reg  [WORD_W-1:0] ext_word_d;
  reg  [3:0]        base_reg_operand_d;
  reg  [6:0]        source_reg_operand_d;
  reg  [6:0]        dest_reg_operand_d;
  reg  [12:0]       file_addr_d;
  reg               default_dest_register_d;
  reg  [3:0]        bit_select_d;
  reg               bit_sel_by_reg_d;
  reg  [15:0]       literal_d;
  reg               acc_sel_d;
  reg  [2:0]        mul_pair_d;
  reg  [3:0]        x_prefetch_d;
  reg  [3:0]        y_prefetch_d;
  reg  [1:0]        awb_d;
  reg  [3:0]        shift_amount_reg_d;
  reg               shift_by_reg_d;
  wire [2:0]        cat;
  wire [2:0]        sub;
  wire              tw;
  dcfd_classify u_cls (
    .opcode     (cls_opc),
    .category   (cat),
    .sub_format (sub),
    .two_word   (tw)
  );
  // operand word being issued: first word, either fresh or held
  wire [WORD_W-1:0] w = (state_q == ST_EXT) ? first_q : fetch_word;
  wire              issue_now = fetch_valid &&
                                ((state_q == ST_IDLE && !tw) || state_q == ST_EXT);

  // word gathering and bubble sequencing
  always @* begin
    state_d = state_q;
    first_d = first_q;
    case (state_q)
      ST_IDLE: begin
        if (fetch_valid && tw) begin
          first_d = fetch_word;
          state_d = ST_EXT;
        end else if (fetch_valid && flow_change) begin
          state_d = ST_BUB;
        end
      end
      ST_EXT: begin
        if (fetch_valid) begin
          state_d = flow_change ? ST_BUB : ST_IDLE;
        end
      end
      ST_BUB: begin
        // a word offered in the bubble slot is dropped; fetch must repeat it
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      first_q <= {WORD_W{1'b0}};
    end else begin
      state_q <= state_d;
      first_q <= first_d;
    end
  end

  // issue fields hold between issues and change together on a word issue; a bubble renews only the nop header
  always @* begin
    issue_valid_d           = 1'b0;
    category_d              = category_q;
    sub_format_d            = sub_format_q;
    opcode_d                = opcode_q;
    two_word_d              = two_word_q;
    ext_word_d              = ext_word_q;
    base_reg_operand_d      = base_reg_operand_q;
    source_reg_operand_d    = source_reg_operand_q;
    dest_reg_operand_d      = dest_reg_operand_q;
    file_addr_d             = file_addr_q;
    default_dest_register_d = default_dest_register_q;
    bit_select_d            = bit_select_q;
    bit_sel_by_reg_d        = bit_sel_by_reg_q;
    literal_d               = literal_q;
    acc_sel_d               = acc_sel_q;
    mul_pair_d              = mul_pair_q;
    x_prefetch_d            = x_prefetch_q;
    y_prefetch_d            = y_prefetch_q;
    awb_d                   = awb_q;
    shift_amount_reg_d      = shift_amount_reg_q;
    shift_by_reg_d          = shift_by_reg_q;
    if (state_q == ST_BUB) begin
      // only the nop header is new, operand fields keep their last value
      issue_valid_d = 1'b1;
      category_d    = `DCFD_CAT_NOP;
      sub_format_d  = `DCFD_SUB_NONE;
      opcode_d      = `DCFD_OPC_NOP;
      two_word_d    = 1'b0;
    end else if (issue_now) begin
      // all fields move together so execution sees one coherent word
      issue_valid_d = 1'b1;
      category_d    = cat;
      sub_format_d  = sub;
      opcode_d      = opc_of(w);
      two_word_d    = (state_q == ST_EXT);
      ext_word_d    = (state_q == ST_EXT) ? fetch_word : {WORD_W{1'b0}};
      // register form: base, source with mode, dest with mode
      base_reg_operand_d   = w[14:11];
      source_reg_operand_d = w[6:0];
      dest_reg_operand_d   = {w[10:7], w[14:12]};
      // file form: address plus destination choice
      file_addr_d             = w[12:0];
      default_dest_register_d = ~w[13];
      // bit form: literal bit number or base register holds it
      bit_select_d     = w[15:12];
      bit_sel_by_reg_d = w[15] & (sub == `DCFD_SUB_NONE) & (cat == `DCFD_CAT_BIT);
      // literal forms: move uses 16-bit value, alu uses 10-bit value
      literal_d = (sub == `DCFD_SUB_LITMOVE) ? w[19:4] :
                  {6'h00, w[13:4]};
      // mac form
      acc_sel_d    = w[15];
      mul_pair_d   = w[18:16];
      x_prefetch_d = w[13:10];
      y_prefetch_d = w[5:2];
      awb_d        = w[1:0];
      // other dsp: shift by register or by literal
      shift_amount_reg_d = w[3:0];
      shift_by_reg_d     = w[14];
    end
  end

  // every output straight from a flop, nop header on reset
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      issue_valid_q           <= 1'b0;
      category_q              <= `DCFD_CAT_NOP;
      sub_format_q            <= `DCFD_SUB_NONE;
      opcode_q                <= `DCFD_OPC_NOP;
      two_word_q              <= 1'b0;
      ext_word_q              <= {WORD_W{1'b0}};
      base_reg_operand_q      <= 4'h0;
      source_reg_operand_q    <= 7'h00;
      dest_reg_operand_q      <= 7'h00;
      file_addr_q             <= 13'h0000;
      default_dest_register_q <= 1'b0;
      bit_select_q            <= 4'h0;
      bit_sel_by_reg_q        <= 1'b0;
      literal_q               <= 16'h0000;
      acc_sel_q               <= 1'b0;
      mul_pair_q              <= 3'h0;
      x_prefetch_q            <= 4'h0;
      y_prefetch_q            <= 4'h0;
      awb_q                   <= 2'h0;
      shift_amount_reg_q      <= 4'h0;
      shift_by_reg_q          <= 1'b0;
    end else begin
      issue_valid_q           <= issue_valid_d;
      category_q              <= category_d;
      sub_format_q            <= sub_format_d;
      opcode_q                <= opcode_d;
      two_word_q              <= two_word_d;
      ext_word_q              <= ext_word_d;
      base_reg_operand_q      <= base_reg_operand_d;
      source_reg_operand_q    <= source_reg_operand_d;
      dest_reg_operand_q      <= dest_reg_operand_d;
      file_addr_q             <= file_addr_d;
      default_dest_register_q <= default_dest_register_d;
      bit_select_q            <= bit_select_d;
      bit_sel_by_reg_q        <= bit_sel_by_reg_d;
      literal_q               <= literal_d;
      acc_sel_q               <= acc_sel_d;
      mul_pair_q              <= mul_pair_d;
      x_prefetch_q            <= x_prefetch_d;
      y_prefetch_q            <= y_prefetch_d;
      awb_q                   <= awb_d;
      shift_amount_reg_q      <= shift_amount_reg_d;
      shift_by_reg_q          <= shift_by_reg_d;
    end
  end
endmodule // dcfd_decoder

// >>> dcfd_decoder_sva.sv
// assertion checker for the instruction format decoder
module dcfd_decoder_sva #(parameter WORD_W = 24) (
  // clock, reset and fetch side
  input wire logic              clk, reset_n, fetch_valid, flow_change,
  // issue side
  input wire logic              issue_valid_q, two_word_q,
  input wire logic [WORD_W-1:0] fetch_word, ext_word_q,
  input wire logic [2:0]        category_q,
  input wire logic [7:0]        opcode_q,
  input wire logic [3:0]        base_reg_operand_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic sec_q, bub_q;
  wire tk = fetch_valid && !bub_q;
  wire op2 = fetch_word[23:16] inside {8'h02, 8'h04, 8'h88};
  wire one = tk && !sec_q && !op2;
  // the slot after a flow change, unless on the first word of a pair, swallows any fetch
  always @(posedge clk or negedge reset_n)
    if (!reset_n) {sec_q, bub_q} <= 2'b0;
    else {sec_q, bub_q} <= {tk ? !sec_q && op2 : sec_q, tk && flow_change && (sec_q || !op2)};
  sequence s_pair; tk && !sec_q && op2 ##1 sec_q && tk; endsequence
  sequence s_flow; one && flow_change ##1 issue_valid_q; endsequence
  property p_pair; s_pair |=> two_word_q && ext_word_q == $past(fetch_word); endproperty
  property p_one; one |=> issue_valid_q && !two_word_q && ext_word_q == '0; endproperty
  property p_opc; one |=> opcode_q == $past(fetch_word[23:16]); endproperty
  property p_base; one |=> base_reg_operand_q == $past(fetch_word[14:11]); endproperty
  property p_bub; s_flow |=> issue_valid_q && category_q == 3'h0; endproperty
  property p_idle; !tk && !bub_q |=> !issue_valid_q; endproperty
  property p_stab; !issue_valid_q |-> $stable(category_q) && $stable(opcode_q); endproperty
  property p_nop; one && fetch_word[23:16] == 8'h00 |=> category_q == 3'h0; endproperty
  a_pair: assert property (p_pair) else $error("pair issue wrong");
  a_one: assert property (p_one) else $error("one word issue wrong");
  a_opc: assert property (p_opc) else $error("opcode wrong");
  a_base: assert property (p_base) else $error("base operand wrong");
  a_bub: assert property (p_bub) else $error("bubble missing");
  a_idle: assert property (p_idle) else $error("issue without fetch");
  a_stab: assert property (p_stab) else $error("fields moved");
  a_nop: assert property (p_nop) else $error("lone word not nop");
endmodule // dcfd_decoder_sva
bind dcfd_decoder dcfd_decoder_sva #(.WORD_W(WORD_W)) u_sva (.clk(clk), .reset_n(reset_n),
  .fetch_valid(fetch_valid), .flow_change(flow_change), .issue_valid_q(issue_valid_q),
  .two_word_q(two_word_q), .fetch_word(fetch_word), .ext_word_q(ext_word_q),
  .category_q(category_q), .opcode_q(opcode_q), .base_reg_operand_q(base_reg_operand_q));

// >>> dcfd_defs.vh
// shared constants for the instruction format decoder
`ifndef DCFD_DEFS_VH
`define DCFD_DEFS_VH
`define DCFD_WORD_W        24
`define DCFD_OPC_MSB       23
`define DCFD_OPC_LSB       16
`define DCFD_CAT_NOP       3'h0
`define DCFD_CAT_WORDBYTE  3'h1
`define DCFD_CAT_BIT       3'h2
`define DCFD_CAT_LITERAL   3'h3
`define DCFD_CAT_DSP       3'h4
`define DCFD_CAT_CONTROL   3'h5
`define DCFD_SUB_NONE      3'h0
`define DCFD_SUB_DEFAULT_DEST_REGISTER      3'h1
`define DCFD_SUB_FILE      3'h2
`define DCFD_SUB_LITMOVE   3'h3
`define DCFD_SUB_LITALU    3'h4
`define DCFD_SUB_MAC       3'h5
`define DCFD_SUB_DSPOTHER  3'h6
`define DCFD_OPC_NOP       8'h00
`define DCFD_OPC_TWOWORD_A 8'h02
`define DCFD_OPC_TWOWORD_B 8'h04
`define DCFD_OPC_TWOWORD_C 8'h88
`endif

// >>> dcfd_fetch_model.sv
// fetch unit model: one 24-bit word per request
module dcfd_fetch_model (
  input  wire logic        clk, req, flow,
  input  wire logic [23:0] word,
  output wire logic        fetch_valid, flow_change,
  output wire logic [23:0] fetch_word
);
  timeunit 1ns; timeprecision 1ps;
  logic [23:0] last_q = 24'h0;
  // idle bus shows the inverse of its own value in the previous cycle, so it never repeats the cycle before
  always @(posedge clk) last_q <= fetch_word;
  assign fetch_valid = req;
  assign flow_change = req & flow;
  assign fetch_word  = req ? word : ~last_q;
endmodule // dcfd_fetch_model

// >>> tb_dsp_core_instruction_format_decoder.sv
// self-checking bench for the instruction format decoder
module tb_dsp_core_instruction_format_decoder;
  timeunit 1ns; timeprecision 1ps;
  logic clk = 1'b0, reset_n = 1'b0, req = 1'b0, flow = 1'b0;
  logic [23:0] word = 24'h0, w, x, fetch_word, ext_word_q;
  logic fetch_valid, flow_change, issue_valid_q, two_word_q;
  logic [2:0] category_q;
  logic [7:0] opcode_q;
  logic [3:0] base_reg_operand_q;
  logic [2:0] sub_format_q, mul_pair_q;
  logic [6:0] source_reg_operand_q, dest_reg_operand_q;
  logic [12:0] file_addr_q;
  logic [15:0] literal_q;
  logic [3:0] bit_select_q, x_prefetch_q, y_prefetch_q, shift_amount_reg_q;
  logic default_dest_register_q, bit_sel_by_reg_q, acc_sel_q, shift_by_reg_q;
  logic [1:0] awb_q;
  logic [40:0] e, exp_q[$];
  logic [70:0] f, fx_q[$];
  logic [7:0] opc [10] = '{8'h40, 8'h7f, 8'h60, 8'ha5, 8'h2c, 8'hb3, 8'hc1, 8'hc9, 8'hf0, 8'h00};
  logic [2:0] cat [10] = '{3'h1, 3'h1, 3'h1, 3'h2, 3'h3, 3'h3, 3'h4, 3'h4, 3'h5, 3'h0};
  logic [2:0] sub [10] = '{3'h1, 3'h2, 3'h2, 3'h0, 3'h3, 3'h4, 3'h5, 3'h6, 3'h0, 3'h0};
  logic [7:0] tw [3] = '{8'h02, 8'h04, 8'h88};
  int n_errors = 0, cmp_count = 0, cyc = 0, seed = 32'h497a;
  always #4 clk = ~clk;
  dcfd_fetch_model u_fetch (.clk(clk), .req(req), .flow(flow), .word(word),
    .fetch_valid(fetch_valid), .flow_change(flow_change), .fetch_word(fetch_word));
  dcfd_decoder DUT (.clk(clk), .reset_n(reset_n), .fetch_word(fetch_word),
    .fetch_valid(fetch_valid), .flow_change(flow_change), .issue_valid_q(issue_valid_q),
    .category_q(category_q), .sub_format_q(sub_format_q), .opcode_q(opcode_q),
    .two_word_q(two_word_q), .ext_word_q(ext_word_q),
    .base_reg_operand_q(base_reg_operand_q), .source_reg_operand_q(source_reg_operand_q),
    .dest_reg_operand_q(dest_reg_operand_q), .file_addr_q(file_addr_q),
    .default_dest_register_q(default_dest_register_q), .bit_select_q(bit_select_q),
    .bit_sel_by_reg_q(bit_sel_by_reg_q), .literal_q(literal_q), .acc_sel_q(acc_sel_q),
    .mul_pair_q(mul_pair_q), .x_prefetch_q(x_prefetch_q), .y_prefetch_q(y_prefetch_q),
    .awb_q(awb_q), .shift_amount_reg_q(shift_amount_reg_q), .shift_by_reg_q(shift_by_reg_q));
  wire [70:0] fld = {sub_format_q, source_reg_operand_q, dest_reg_operand_q, file_addr_q,
    default_dest_register_q, bit_select_q, bit_sel_by_reg_q, literal_q, acc_sel_q,
    mul_pair_q, x_prefetch_q, y_prefetch_q, awb_q, shift_amount_reg_q, shift_by_reg_q};
  task automatic check(input string nm, input logic [39:0] ex, got);
    cmp_count++;
    if (got !== ex) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, ex, got);
    end
  endtask
  task automatic check_f(input string nm, input logic [70:0] ex, got);
    cmp_count++;
    if (got !== ex) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, ex, got);
    end
  endtask
  // expected operand fields follow the fixed field positions of the first word
  task automatic expect_issue(input logic [23:0] v, input logic [2:0] c, s,
                              input logic t, input logic [23:0] xw);
    exp_q.push_back({1'b0, c, v[23:16], t, xw, v[14:11]});
    fx_q.push_back({s, v[6:0], v[10:7], v[14:12], v[12:0], ~v[13], v[15:12],
                    v[15] & (c == 3'h2) & (s == 3'h0), (s == 3'h3) ? v[19:4] : {6'h00, v[13:4]},
                    v[15], v[18:16], v[13:10], v[5:2], v[1:0], v[3:0], v[14]});
  endtask
  task automatic final_report();
    if (n_errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic send(input logic [23:0] v, input logic f);
    @(negedge clk);
    {req, word, flow} = {1'b1, v, f};
  endtask
  always @(negedge clk) if (issue_valid_q === 1'b1) begin
    if (exp_q.size() == 0) begin
      check("spare issue", 40'h0, 40'h1);
    end else begin
      e = exp_q.pop_front();
      if (e[40]) begin
        check("bubble", 40'h0,
          {25'h0, category_q, sub_format_q, opcode_q, two_word_q});
      end else begin
        check("issue", e[39:0],
          {category_q, opcode_q, two_word_q, ext_word_q, base_reg_operand_q});
        f = fx_q.pop_front();
        check_f("fields", f, fld);
      end
    end
  end
  always @(posedge clk) if (++cyc == 1000) begin
    n_errors++;
    final_report();
  end
  initial begin
    repeat (8) @(posedge clk);
    check("reset", 40'h0, {category_q, opcode_q, two_word_q, ext_word_q, issue_valid_q, 3'h0});
    check_f("reset fields", 71'h0, fld);
    @(negedge clk) reset_n = 1'b1;
    foreach (opc[i]) begin
      w = {opc[i], 16'($random(seed))};
      send(w, 1'b0);
      expect_issue(w, cat[i], sub[i], 1'b0, 24'h0);
    end
    // two-word opcodes fall in the control category
    foreach (tw[i]) begin
      w = {tw[i], 16'($random(seed))};
      x = {8'h00, 16'($random(seed))};
      send(w, 1'b0);
      send(x, 1'b0);
      expect_issue(w, 3'h5, 3'h0, 1'b1, x);
    end
    w = {8'h41, 16'($random(seed))};
    send(w, 1'b1);
    expect_issue(w, 3'h1, 3'h1, 1'b0, 24'h0);
    exp_q.push_back({1'b1, 40'h0});
    // a word offered in the bubble slot must vanish
    send(~w, 1'b0);
    // flow change on the second word of a pair
    w = {8'h88, 16'($random(seed))};
    x = {8'h00, 16'($random(seed))};
    send(w, 1'b0);
    send(x, 1'b1);
    expect_issue(w, 3'h5, 3'h0, 1'b1, x);
    exp_q.push_back({1'b1, 40'h0});
    @(negedge clk) {req, flow} = 2'b0;
    repeat (4) @(negedge clk);
    check("left", 40'h0, 40'(exp_q.size() + fx_q.size()));
    final_report();
  end
endmodule // tb_dsp_core_instruction_format_decoder
